// ==== bas_pkg.sv ====
// Package for the burst address sequencer: bus widths, codes and burst constants.
// Assumes one clock domain shared by both ends of the bus.
package bas_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 32;
  localparam int REQ_W      = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LINE_BEATS = 8;

  // ----------------------------------------------------------------------
  // Byte-enable codes, active low, bit 3 down to bit 0
  // ----------------------------------------------------------------------
  localparam logic [3:0] BE_LOW_WORD  = 4'h0;
  localparam logic [3:0] BE_HIGH_WORD = 4'h3;
  localparam logic [3:0] BE_NONE      = 4'hF;

  // ----------------------------------------------------------------------
  // Request kinds given on the device's user side
  // ----------------------------------------------------------------------
  localparam logic [1:0] KIND_READ     = 2'h0;
  localparam logic [1:0] KIND_WRITE    = 2'h1;
  localparam logic [1:0] KIND_PREFETCH = 2'h2;

  // Transfer sizes in bytes.
  localparam logic [2:0] SIZE_BYTE  = 3'h1;
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h4;

  localparam logic [2:0] LAST_BEAT = 3'h7;

endpackage

// ==== bas_bus_if.sv ====
// Interface joining the processor end and the memory-controller end of the bus.
// Data lines are split into drive and sample halves; each end samples the other end's drive half directly.
interface bas_bus_if;
  logic        start;
  logic [31:2] addr;
  logic [3:0]  lane_enables_n;
  logic        last_cycle_n;
  logic        mem_io;
  logic        wr_rd;
  logic        data_code;
  logic        page_cache_disable;
  logic        lock_n;
  logic        cacheable_ack_n;
  logic        ready_n;
  logic [15:0] dev_dout;
  logic        dev_doe;
  logic [15:0] ctl_dout;
  logic        ctl_doe;
  logic        upper_lane_parity;
  logic        lower_lane_parity;

  modport dev
  (
    output start, addr, lane_enables_n, last_cycle_n, mem_io, wr_rd, data_code,
    output page_cache_disable, lock_n, dev_dout, dev_doe,
    input  cacheable_ack_n, ready_n, ctl_dout, ctl_doe, upper_lane_parity,
    input  lower_lane_parity
  );

  modport ctl
  (
    input  start, addr, lane_enables_n, last_cycle_n, mem_io, wr_rd, data_code,
    input  page_cache_disable, lock_n, dev_dout, dev_doe,
    output cacheable_ack_n, ready_n, ctl_dout, ctl_doe, upper_lane_parity,
    output lower_lane_parity
  );
endinterface

// ==== bas_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; storage is flip-flops indexed by pointer.
module bas_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_B,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;

  wire push = i_in_valid && (cnt_r != (AW+1)'(DEPTH));
  wire pop  = i_out_ready && (cnt_r != '0);

  assign o_in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_r != '0;
  assign o_out_data  = mem_r[rp_r];

  always_ff @(posedge I_MCLK)
  begin
    if (push)
    begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== bas_dev.sv ====
// Processor end of the burst bus: splits requests into 16-bit data cycles.
// Assumes the controller end shares I_MCLK and answers each cycle with ready_n.
// Summary of operation
// RULE1: Split transfers wider than 16 bits into cycles.
// RULE2: Misaligned 16-bit word takes two cycles.
// RULE3: Multi-cycle reads may run as bursts.
// RULE4: Misaligned writes may also burst.
// RULE5: Line fill bursts eight 16-bit cycles.
// RULE6: Controller ignores first fill-cycle byte enables.
// RULE7: Line fill starts 4-byte aligned.
// RULE8: Later fill cycles decode byte enables normally.
// RULE9: Upper address and cycle type held during fill.
// RULE10: Fill may end early via last-cycle low.
// RULE11: Groups visited in interleaved bits 3:2 order.
// RULE12: Enables 0000 then 0011; last low cycle eight.
// RULE13: Controller returns even byte low, odd high.
// RULE14: Idle cache prefetches in 16-byte bursts.
// RULE15: Prefetch holds upper address and cycle type.
// RULE16: Prefetch may be cut short anytime.
// RULE17: Controller may anticipate burst order.
// RULE18: Cacheable only with PAGE_CACHE_DISABLE low, lock high, ack low.
// RULE19: Low enable always active; high except final.
// RULE20: Controller derives A1 and byte selects. Here the controller derives only A1.
module bas_dev (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_REQ_VALID,
  output logic             O_REQ_READY,
  input  wire logic [1:0]  I_REQ_KIND,
  input  wire logic [31:0] I_REQ_ADDR,
  input  wire logic [2:0]  I_REQ_SIZE,
  input  wire logic [31:0] I_REQ_WDATA,
  input  wire logic        I_REQ_NOCACHE,
  input  wire logic        I_REQ_LOCK,
  input  wire logic        I_CUT,
  output logic             O_RD_VALID,
  input  wire logic        I_RD_READY,
  output logic [15:0]      O_RD_DATA,
  output logic             O_BUSY,
  bas_bus_if.dev           bus
);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum {BAS_IDLE, BAS_ISSUE, BAS_WAIT, BAS_SAMPLE} bas_state_t;

  bas_state_t  st_r;
  logic [1:0]  kind_r;
  logic [31:0] addr_r;
  logic [2:0]  size_r;
  logic [31:0] wdata_r;
  logic [2:0]  beat_r;
  logic [2:0]  nbeats_r;
  logic        fill_r;
  logic        fill_tried_r;
  logic        pcd_r;
  logic        lock_r;
  logic        cut_r;
  logic [1:0]  grp0_r;
  logic        last_seen_r;
  logic        last_n_r;
  logic [15:0] din_r;

  // One-beat or two-beat count for ordinary transfers; misaligned words and
  // any doubleword need two cycles because the bus is only 16 bits wide.
  // The controller end shares the clock, so its outputs are read directly.
  wire         misal     = addr_r[0] && (size_r != bas_pkg::SIZE_BYTE);         // [RULE2]
  wire         wide      = size_r == bas_pkg::SIZE_DWORD;                       // [RULE1]
  wire         can_fill  = (kind_r == bas_pkg::KIND_READ) && !pcd_r && !lock_r;
  wire         cacheable = can_fill && !bus.cacheable_ack_n;                    // [RULE18]
  // A read that may become a fill shows the line pattern from its first beat.
  wire         try_fill  = cacheable && !fill_tried_r;
  wire         line_kind = (kind_r == bas_pkg::KIND_PREFETCH) || fill_r
                           || try_fill;                                         // [RULE14]
  wire [2:0]   last_idx  = try_fill ? bas_pkg::LAST_BEAT : nbeats_r;
  wire [2:0]   plain_n   = (wide || misal) ? 3'h1 : 3'h0;
  wire [1:0]   grp       = grp0_r ^ beat_r[2:1];                                // [RULE11]
  wire [3:0]   line_be   = beat_r[0] ? bas_pkg::BE_HIGH_WORD
                                     : bas_pkg::BE_LOW_WORD;                    // [RULE12]
  wire [3:0]   plain_be  = (beat_r == 3'h0) ? ~(4'(4'hF << addr_r[1:0]))
                                            : bas_pkg::BE_HIGH_WORD;
  wire [3:0]   be_now    = line_kind ? line_be : plain_be;
  wire         is_last   = (beat_r == last_idx) || cut_r;                       // [RULE10] [RULE16]
  wire         beat_done = st_r == bas_state_t'(BAS_SAMPLE);
  wire [15:0]  wword     = beat_r[0] ? wdata_r[31:16] : wdata_r[15:0];
  wire         rd_push   = beat_done && (kind_r != bas_pkg::KIND_WRITE);
  logic        fifo_ready;

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      st_r         <= BAS_IDLE;
      kind_r       <= bas_pkg::KIND_READ;
      addr_r       <= '0;
      size_r       <= bas_pkg::SIZE_BYTE;
      wdata_r      <= '0;
      beat_r       <= '0;
      nbeats_r     <= '0;
      fill_r       <= 1'b0;
      fill_tried_r <= 1'b0;
      pcd_r        <= 1'b0;
      lock_r       <= 1'b0;
      cut_r        <= 1'b0;
      grp0_r       <= '0;
      last_seen_r  <= 1'b0;
    end
    else
    begin
      case (st_r)
        BAS_IDLE:
        begin
          // Reads wait for an empty buffer, which holds a whole line, so a
          // burst never has to stall once it has begun.
          if (I_REQ_VALID && (!O_RD_VALID || (I_REQ_KIND == bas_pkg::KIND_WRITE)))
          begin
            last_seen_r  <= 1'b0;
            kind_r       <= I_REQ_KIND;
            addr_r       <= I_REQ_ADDR;
            size_r       <= I_REQ_SIZE;
            wdata_r      <= I_REQ_WDATA;
            pcd_r        <= I_REQ_NOCACHE;
            lock_r       <= I_REQ_LOCK;
            grp0_r       <= I_REQ_ADDR[3:2];
            beat_r       <= '0;
            cut_r        <= 1'b0;
            fill_r       <= 1'b0;
            fill_tried_r <= 1'b0;
            nbeats_r     <= (I_REQ_KIND == bas_pkg::KIND_PREFETCH) ? bas_pkg::LAST_BEAT
                                                                   : 3'h0;
            st_r         <= BAS_ISSUE;
          end
        end
        BAS_ISSUE:
        begin
          if (!line_kind)
          begin
            nbeats_r <= plain_n;                                                // [RULE3] [RULE4]
          end
          st_r <= BAS_WAIT;
        end
        BAS_WAIT:
        begin
          if (I_CUT) cut_r <= 1'b1;
          // The cacheable answer is taken with the first cycle's ready, and
          // the burst ends after the beat that showed last_cycle_n low.
          if (!bus.ready_n)
          begin
            last_seen_r <= !last_n_r;
            if (!fill_tried_r)
            begin
              fill_tried_r <= 1'b1;
              if (cacheable)
              begin
                fill_r   <= 1'b1;                                               // [RULE5]
                nbeats_r <= bas_pkg::LAST_BEAT;
              end
            end
            st_r <= BAS_SAMPLE;
          end
        end
        BAS_SAMPLE:
        begin
          if (last_seen_r)
          begin
            st_r <= BAS_IDLE;
          end
          else
          begin
            beat_r <= beat_r + 3'h1;
            st_r   <= BAS_WAIT;
          end
        end
        default: st_r <= BAS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus outputs, registered or decoded from registered request fields; mem_io tied high
  // ----------------------------------------------------------------------
  logic        start_r, doe_r;
  logic [31:2] bus_addr_r;
  logic [3:0]  be_r;
  logic [15:0] dout_r;

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      start_r    <= 1'b0;
      last_n_r   <= 1'b1;
      bus_addr_r <= '0;
      be_r       <= bas_pkg::BE_NONE;
      dout_r     <= '0;
      doe_r      <= 1'b0;
    end
    else
    begin
      start_r    <= st_r == BAS_ISSUE;
      // Bits 31:4 never change inside a burst; only bits 3:2 walk.
      bus_addr_r <= {addr_r[31:4], (line_kind ? grp : addr_r[3:2])};           // [RULE9] [RULE15] [RULE7]
      be_r       <= (st_r == BAS_IDLE) ? bas_pkg::BE_NONE : be_now;             // [RULE19]
      last_n_r   <= !((st_r == BAS_WAIT) && is_last);                           // [RULE12]
      dout_r     <= wword;
      doe_r      <= (kind_r == bas_pkg::KIND_WRITE) && (st_r != BAS_IDLE);
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (st_r == BAS_WAIT)
    begin
      din_r <= bus.ctl_dout;
    end
  end

  assign bus.start              = start_r;
  assign bus.addr               = bus_addr_r;
  assign bus.lane_enables_n     = be_r;
  assign bus.last_cycle_n       = last_n_r;
  assign bus.mem_io             = 1'b1;
  assign bus.wr_rd              = kind_r == bas_pkg::KIND_WRITE;
  assign bus.data_code          = kind_r != bas_pkg::KIND_PREFETCH;
  assign bus.page_cache_disable = pcd_r;
  assign bus.lock_n             = !lock_r;
  assign bus.dev_dout           = dout_r;
  assign bus.dev_doe            = doe_r;

  // ----------------------------------------------------------------------
  // Read data buffer; a non-empty buffer holds off the next read request
  // ----------------------------------------------------------------------
  bas_fifo #(.WIDTH(bas_pkg::DATA_W), .DEPTH(bas_pkg::FIFO_DEPTH)) u_rd_fifo (
    .I_MCLK      (I_MCLK),
    .I_RST_B     (I_RST_B),
    .i_in_valid  (rd_push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (din_r),
    .o_out_valid (O_RD_VALID),
    .i_out_ready (I_RD_READY),
    .o_out_data  (O_RD_DATA)
  );

  logic busy_r, req_ready_r;
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      busy_r      <= 1'b0;
      req_ready_r <= 1'b0;
    end
    else
    begin
      busy_r      <= st_r != BAS_IDLE;
      req_ready_r <= (st_r == BAS_SAMPLE) && last_seen_r;
    end
  end
  assign O_BUSY      = busy_r;
  assign O_REQ_READY = req_ready_r;
endmodule

// ==== bas_ctl.sv ====
// Memory controller end: follows the burst order and answers each data cycle.
// Assumes the processor end shares I_MCLK; one ready pulse answers each beat.
module bas_ctl (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_CACHEABLE,
  input  wire logic [15:0] I_FILL_WORD,
  output logic             O_WR_VALID,
  output logic [31:0]      O_WR_ADDR,
  output logic [15:0]      O_WR_DATA,
  bas_bus_if.ctl           bus
);
  logic        rdy_n_r, ack_n_r, wv_r;
  logic [1:0]  gap_r;
  logic [31:0] wa_r;
  logic [15:0] wd_r, rd_r;

  // First fill cycle forces A1 low; later ones decode it from the lane enables.
  wire        first     = bus.start && !ack_n_r && !bus.page_cache_disable
                          && bus.lock_n && !bus.wr_rd;                          // [RULE6] [RULE18]
  wire        a1        = !first
                          && (bus.lane_enables_n == bas_pkg::BE_HIGH_WORD);     // [RULE8] [RULE20]
  wire [31:0] byte_addr = {bus.addr, a1, 1'b0};                                 // [RULE7]
  // The next beat's address is on the bus three cycles after a ready, so
  // the following ready comes four cycles later, with no wait beyond that.
  wire        more      = !rdy_n_r && bus.last_cycle_n;                         // [RULE17]

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      gap_r   <= 2'h0;
      rdy_n_r <= 1'b1;
      ack_n_r <= 1'b1;
      wv_r    <= 1'b0;
      wa_r    <= '0;
      wd_r    <= '0;
      rd_r    <= '0;
    end
    else
    begin
      ack_n_r <= !I_CACHEABLE;
      if (bus.start)
      begin
        rdy_n_r <= 1'b0;
        gap_r   <= 2'h0;
      end
      else if (more)
      begin
        rdy_n_r <= 1'b1;
        gap_r   <= 2'h3;
      end
      else if (gap_r != 2'h0)
      begin
        rdy_n_r <= gap_r != 2'h1;
        gap_r   <= gap_r - 2'h1;
      end
      else
      begin
        rdy_n_r <= 1'b1;
      end
      // Even byte on the low lane, odd byte on the high lane.
      rd_r    <= I_FILL_WORD ^ {8'(byte_addr[7:0] + 8'h1), byte_addr[7:0]};     // [RULE13]
      wv_r    <= bus.dev_doe && !rdy_n_r;
      wa_r    <= byte_addr;
      wd_r    <= bus.dev_dout;
    end
  end

  assign bus.ready_n           = rdy_n_r;
  assign bus.cacheable_ack_n   = ack_n_r;
  assign bus.ctl_dout          = rd_r;
  assign bus.ctl_doe           = !bus.dev_doe;
  assign bus.upper_lane_parity = ~^rd_r[15:8];
  assign bus.lower_lane_parity = ~^rd_r[7:0];
  assign O_WR_VALID            = wv_r;
  assign O_WR_ADDR             = wa_r;
  assign O_WR_DATA             = wd_r;
endmodule

// ==== bas_asserts.sv ====
// Concurrent checks on the bus that joins the two ends of the sequencer.
// Assumes one clock domain and the bus signals wired in by name.
module bas_asserts (
  input wire logic        I_MCLK,
  input wire logic        I_RST_B,
  input wire logic        start,
  input wire logic [31:2] addr,
  input wire logic [3:0]  lane_enables_n,
  input wire logic        last_cycle_n,
  input wire logic        mem_io,
  input wire logic        wr_rd,
  input wire logic        data_code,
  input wire logic        ready_n
);
  logic [3:0] beat_r;
  logic [3:0] beat_nxt;
  logic [1:0] grp_r;
  logic [1:0] grp_nxt;
  logic       busy_r;
  logic       busy_nxt;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  // ----------------------------------------------------------------------
  // Burst tracking
  // ----------------------------------------------------------------------
  // Beats are counted from each start, so a later single cycle never
  // inherits the position of an earlier burst.
  assign beat_nxt = start ? 4'h0 : (ready_n ? beat_r : beat_r + 4'h1);
  assign grp_nxt  = start ? addr[3:2] : grp_r;
  assign busy_nxt = start | (busy_r & ~(~ready_n & ~last_cycle_n));

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      beat_r <= 4'h0;
      grp_r  <= 2'h0;
      busy_r <= 1'b0;
    end
    else
    begin
      beat_r <= beat_nxt;
      grp_r  <= grp_nxt;
      busy_r <= busy_nxt;
    end
  end

  sequence s_beat;
    !ready_n;
  endsequence

  sequence s_final;
    !ready_n && !last_cycle_n;
  endsequence

  sequence s_later_beat;
    !ready_n && beat_r >= 4'h2;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_upper_addr_hold: assert property (busy_r && !start |->
    $stable(addr[31:4]) && $stable({mem_io, wr_rd, data_code}))
    else $error("Upper address or cycle type moved inside a burst.");
  a_group_order: assert property (s_later_beat |-> addr[3:2] == (grp_r ^ beat_r[2:1]))
    else $error("Burst visited the line groups out of order.");
  a_lane_pattern: assert property (s_later_beat |->
    lane_enables_n == (beat_r[0] ? 4'h3 : 4'h0))
    else $error("Lane enables broke the low then high word pattern.");
  a_last_at_eight: assert property (!ready_n && beat_r == 4'h7 |-> !last_cycle_n)
    else $error("Eighth beat was not marked as the last.");
  a_burst_max_eight: assert property (s_beat |-> beat_r <= 4'h7)
    else $error("Burst ran past eight beats.");
  a_write_two_beats: assert property (!ready_n && wr_rd |-> beat_r <= 4'h1)
    else $error("Write burst longer than two beats.");
  a_lower_lane_on: assert property (!ready_n && beat_r != 4'h0 |->
    !(lane_enables_n[0] && lane_enables_n[2]))
    else $error("Lower byte select inactive inside a burst.");
  a_upper_lane_on: assert property (!ready_n && last_cycle_n |->
    !(lane_enables_n[1] && lane_enables_n[3]))
    else $error("Upper byte select inactive before the final beat.");
  a_final_quiet: assert property (s_final |=> ready_n)
    else $error("Beat answered right after the last beat.");
endmodule

// ==== bas_tb.sv ====
// Self-checking bench: processor end and controller end joined by the bus.
// Assumes package, interface, FIFO and both ends are compiled first.
module bas_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] T_SIZE  [7] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h4, 3'h2};
  localparam logic [3:0] T_OFF   [7] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h3, 4'h0, 4'h1};
  localparam int         T_BEATS [7] = '{2, 2, 2, 1, 1, 2, 2};
  logic        mclk, rst_b, req_valid, req_nocache, req_lock, cut, rd_ready, cacheable;
  logic        req_ready, rd_valid, busy, wr_valid;
  logic [1:0]  req_kind;
  logic [2:0]  req_size;
  logic [31:0] req_addr, req_wdata, seed, a;
  logic [15:0] fill_word, wr_data, rd_data;
  logic [6:0]  beat_q[$];
  logic [15:0] wr_q[$];
  int          error_cnt, num_checks, cyc, nrd, n;

  bas_bus_if bus ();
  bas_dev u_bas_dev (.I_MCLK(mclk), .I_RST_B(rst_b), .I_REQ_VALID(req_valid),
    .O_REQ_READY(req_ready), .I_REQ_KIND(req_kind), .I_REQ_ADDR(req_addr),
    .I_REQ_SIZE(req_size), .I_REQ_WDATA(req_wdata), .I_REQ_NOCACHE(req_nocache),
    .I_REQ_LOCK(req_lock), .I_CUT(cut), .O_RD_VALID(rd_valid), .I_RD_READY(rd_ready),
    .O_RD_DATA(rd_data), .O_BUSY(busy), .bus(bus));
  bas_ctl u_bas_ctl (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CACHEABLE(cacheable),
    .I_FILL_WORD(fill_word), .O_WR_VALID(wr_valid), .O_WR_ADDR(), .O_WR_DATA(wr_data),
    .bus(bus));
  bas_asserts u_bas_asserts (.I_MCLK(mclk), .I_RST_B(rst_b), .start(bus.start),
    .addr(bus.addr), .lane_enables_n(bus.lane_enables_n), .last_cycle_n(bus.last_cycle_n),
    .mem_io(bus.mem_io), .wr_rd(bus.wr_rd), .data_code(bus.data_code), .ready_n(bus.ready_n));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // Bus monitor and hang guard
  // ----------------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
    if (rst_b && bus.ready_n === 1'b0)
      beat_q.push_back({bus.addr[3:2], bus.lane_enables_n, bus.last_cycle_n});
    if (rd_valid === 1'b1 && rd_ready)
      nrd++;
    if (wr_valid === 1'b1)
      wr_q.push_back(wr_data);
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [6:0] exp_beat(input logic [1:0] g, input int i, input int last);
    return {g ^ i[2:1], (i[0] ? 4'h3 : 4'h0), ((i == last) ? 1'b0 : 1'b1)};
  endfunction

  task automatic chk_seq(input logic [1:0] g, input int cnt);
    check("beat count", beat_q.size(), cnt);
    foreach (beat_q[i])
      check("beat", beat_q[i], exp_beat(g, i, cnt - 1));
  endtask

  // The request is held until the device shows busy, so a refused one is not lost.
  task automatic run(input logic [1:0] k, input logic [31:0] ad, input logic [2:0] s,
                     input logic nc, input logic lk, input int cut_at, input int hold);
    @(negedge mclk);
    beat_q.delete();
    wr_q.delete();
    nrd = 0;
    req_valid = 1'b1;
    req_kind = k;
    req_addr = ad;
    req_size = s;
    req_nocache = nc;
    req_lock = lk;
    req_wdata = $random(seed);
    n = 0;
    while (req_ready !== 1'b1 && n < 400)
    begin
      if (beat_q.size() == cut_at)
        cut = 1'b1;
      if (n == hold)
        rd_ready = 1'b1;
      @(negedge mclk);
      if (busy === 1'b1)
        req_valid = 1'b0;
      n++;
    end
    req_valid = 1'b0;
    cut = 1'b0;
    check("request done", n < 400, 1'b1);
    repeat (4) @(negedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    seed = 32'h885226EB;
    {rst_b, req_valid, req_nocache, req_lock, cut, cyc, error_cnt, num_checks} = '0;
    {req_kind, req_size, req_addr, req_wdata} = '0;
    rd_ready = 1'b1;
    cacheable = 1'b1;
    fill_word = $random(seed);
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    for (int g = 0; g < 4; g++)
    begin
      a = $random(seed);
      a[3:2] = g[1:0];
      run(bas_pkg::KIND_READ, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, -1, -1);
      chk_seq(a[3:2], 8);
      check("words read", nrd, 8);
      $display("Line fill from group %0d done", g);
    end
    cacheable = 1'b0;
    run(bas_pkg::KIND_PREFETCH, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, -1, -1);
    chk_seq(a[3:2], 8);
    run(bas_pkg::KIND_PREFETCH, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, 3, -1);
    check("prefetch cut", beat_q.size() < 8, 1'b1);
    chk_seq(a[3:2], beat_q.size());
    cacheable = 1'b1;
    run(bas_pkg::KIND_READ, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, 2, -1);
    check("fill cut", beat_q.size() < 8, 1'b1);
    chk_seq(a[3:2], beat_q.size());
    $display("Prefetch and cut bursts done");
    for (int t = 0; t < 7; t++)
    begin
      a = $random(seed);
      a[3:0] = T_OFF[t];
      run((t < 5) ? bas_pkg::KIND_READ : bas_pkg::KIND_WRITE, a, T_SIZE[t],
          (t != 1 && t < 5), (t == 1), -1, -1);
      check("short beats", beat_q.size(), T_BEATS[t]);
      if (t == 0 || t == 5)
        chk_seq(a[3:2], 2);
      if (t == 5)
      begin
        check("write count", wr_q.size(), 2);
        check("write low", wr_q[0], req_wdata[15:0]);
        check("write high", wr_q[1], req_wdata[31:16]);
      end
    end
    $display("Short transfers done");
    rd_ready = 1'b0;
    a = $random(seed);
    a[3:2] = 2'h2;
    run(bas_pkg::KIND_READ, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, -1, -1);
    check("buffer full", rd_valid, 1'b1);
    run(bas_pkg::KIND_READ, a, bas_pkg::SIZE_DWORD, 1'b0, 1'b0, -1, 60);
    check("stall while full", n > 60, 1'b1);
    chk_seq(2'h2, 8);
    repeat (20) @(negedge mclk);
    check("words drained", nrd, 16);
    check("buffer empty", rd_valid, 1'b0);
    $display("Buffer full and drain done");
    report_and_stop();
  end
endmodule
